//--- core/spt_core.sv
`timescale 1ns/1ps
module spt_core #(
  parameter int MAINS_GAP_CYC = spt_pkg::MAINS_GAP_CYC
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // Pacing clocks, sampled as levels
  input wire logic i_clk20k,
  input wire logic i_osc320k,
  // Ramp comparators
  input wire logic i_ramp_over_ctrl,
  input wire logic i_ramp_over_limit,
  // Mode comparators
  input wire logic i_volt_below_port,
  input wire logic i_amp_below_port,
  // Supply monitors
  input wire logic i_bias_ok,
  input wire logic i_mains_present,
  input wire logic i_mains_surge,
  // Protection
  input wire logic i_out_overvolt,
  input wire logic i_remote_reset,
  // Modulator and switch drive
  output logic o_pwm,
  output logic o_switch_on,
  output logic o_on_pulse,
  output logic o_off_pulse,
  output logic o_control_cutoff_n,
  output logic o_power_cutoff_n,
  // Turn-on control
  output logic o_power_clear,
  output logic o_relay_enable,
  output logic o_pwm_permit,
  output logic o_master_gate,
  output logic o_down_prog,
  // Trip and lamps
  output logic o_trip_latch,
  output logic o_trip_lamp,
  output logic o_volt_reg_lamp,
  output logic o_amp_reg_lamp,
  output logic o_unreg_lamp
);
  localparam int GAP_W = $clog2(MAINS_GAP_CYC + 1);
  localparam logic [GAP_W-1:0] GAP_LAST = GAP_W'(MAINS_GAP_CYC - 1);
  localparam logic [spt_pkg::PHASE_W-1:0] PHASE_LAST = spt_pkg::PHASE_W'(spt_pkg::ON_PERIOD_CYC - 1);
  localparam logic [spt_pkg::NUM_W-1:0] NUM_MAX = spt_pkg::NUM_W'(spt_pkg::ON_PULSES_MAX);
  localparam logic [spt_pkg::WID_W-1:0] WID_LOAD = spt_pkg::WID_W'(spt_pkg::PULSE_W_CYC);

  spt_seq_if sif ();

  // ****************************************
  // Power clear and supply monitors
  // ****************************************
  logic power_clear;
  logic clk20_q;
  logic osc_q;
  logic [GAP_W-1:0] gap_cnt;
  logic mains_bad;

  // Bias must be good for a whole cycle before the block is let go
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      power_clear <= 1'b0;
    end else begin
      power_clear <= i_bias_ok;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      clk20_q <= 1'b0;
      osc_q <= 1'b0;
    end else begin
      clk20_q <= i_clk20k;
      osc_q <= i_osc320k;
    end
  end

  wire clk20_rise = i_clk20k && !clk20_q;
  wire clk20_fall = !i_clk20k && clk20_q;
  wire osc_rise = i_osc320k && !osc_q;
  wire gap_full = (gap_cnt == GAP_LAST);

  // Counts while mains detect is absent; saturates so a long outage stays bad
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || i_mains_present) begin
      gap_cnt <= '0;
    end else if (!gap_full) begin
      gap_cnt <= gap_cnt + 1'b1;
    end
  end

  // Restart only once mains is back and in range
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      mains_bad <= 1'b0;
    end else if (i_mains_surge || (gap_full && !i_mains_present)) begin
      mains_bad <= 1'b1;
    end else if (i_mains_present) begin
      mains_bad <= 1'b0;
    end
  end

  // ****************************************
  // Turn-on sequencer
  // ****************************************
  assign sif.seq_clear = mains_bad || !power_clear;
  assign sif.clk20_rise = clk20_rise;

  spt_seq u_seq (
    .i_ref_clk (i_ref_clk),
    .i_rstn (i_rstn),
    .sif (sif)
  );

  // ****************************************
  // Trip latch
  // ****************************************
  logic trip_latch;

  // Set wins over either clear so a fresh overvoltage is never lost
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      trip_latch <= 1'b0;
    end else if (i_out_overvolt) begin
      trip_latch <= 1'b1;
    end else if (!power_clear || i_remote_reset) begin
      trip_latch <= 1'b0;
    end
  end

  wire pwm_permit = sif.permit && !mains_bad;
  wire master_gate = pwm_permit && !trip_latch;

  // ****************************************
  // Modulator
  // ****************************************
  logic ctrl_cut_n;
  logic pow_cut_n;
  logic delay_q;
  logic delay_d;
  logic pwm_q;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      ctrl_cut_n <= 1'b0;
      pow_cut_n <= 1'b0;
    end else begin
      ctrl_cut_n <= !i_ramp_over_ctrl;
      pow_cut_n <= !i_ramp_over_limit;
    end
  end

  // The clock pulse itself is the duty limit: no pulse while i_clk20k is high
  wire duty_ok_n = !i_clk20k;
  wire cut_all_n = ctrl_cut_n && pow_cut_n && duty_ok_n && master_gate;

  // Delay flop: cleared while the clock pulse stands, set by the first
  // oscillator edge after its trailing edge; stays set for the period
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || i_clk20k) begin
      delay_q <= 1'b0;
    end else if (osc_rise) begin
      delay_q <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      delay_d <= 1'b0;
    end else begin
      delay_d <= delay_q;
    end
  end

  wire delay_rise = delay_q && !delay_d;

  // Cutoff dominates the set, as the AND gate drives a direct reset
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || !cut_all_n) begin
      pwm_q <= 1'b0;
    end else if (delay_rise) begin
      pwm_q <= 1'b1;
    end
  end

  // ****************************************
  // Switch drive
  // ****************************************
  logic pwm_d;
  logic [spt_pkg::PHASE_W-1:0] phase;
  logic [spt_pkg::NUM_W-1:0] on_num;
  logic [spt_pkg::WID_W-1:0] on_wid;
  logic [spt_pkg::WID_W-1:0] off_wid;
  logic switch_on;

  wire pwm_rise = pwm_q && !pwm_d;
  wire pwm_fall = !pwm_q && pwm_d;
  wire phase_wrap = (phase == PHASE_LAST);
  wire more_on = pwm_q && phase_wrap && (on_num < NUM_MAX);

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      pwm_d <= 1'b0;
    end else begin
      pwm_d <= pwm_q;
    end
  end

  // On-pulse phase restarts at each modulator pulse
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || !pwm_q) begin
      phase <= '0;
    end else if (phase_wrap) begin
      phase <= '0;
    end else begin
      phase <= phase + 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || !pwm_q) begin
      on_num <= '0;
    end else if (pwm_rise || more_on) begin
      on_num <= on_num + 1'b1;
    end
  end

  // On-pulses stop at once on bias loss, in the same cycle as power clear falls
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || !power_clear || !i_bias_ok || !pwm_q) begin
      on_wid <= '0;
    end else if (pwm_rise || more_on) begin
      on_wid <= WID_LOAD;
    end else if (on_wid != '0) begin
      on_wid <= on_wid - 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      off_wid <= '0;
    end else if (pwm_fall) begin
      off_wid <= WID_LOAD;
    end else if (off_wid != '0) begin
      off_wid <= off_wid - 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      switch_on <= 1'b0;
    end else begin
      switch_on <= pwm_q && power_clear;
    end
  end

  // ****************************************
  // Lamps
  // ****************************************
  logic volt_lamp;
  logic amp_lamp;
  logic unreg_lamp;

  // Unregulated lamp is the NOR of the two regulating indications
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      volt_lamp <= 1'b0;
      amp_lamp <= 1'b0;
      unreg_lamp <= 1'b0;
    end else begin
      volt_lamp <= i_volt_below_port;
      amp_lamp <= i_amp_below_port;
      unreg_lamp <= !(i_volt_below_port || i_amp_below_port);
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_pwm = pwm_q;
  assign o_switch_on = switch_on;
  assign o_on_pulse = (on_wid != '0);
  assign o_off_pulse = (off_wid != '0);
  assign o_control_cutoff_n = ctrl_cut_n;
  assign o_power_cutoff_n = pow_cut_n;
  assign o_power_clear = power_clear;
  assign o_relay_enable = sif.relay_en && power_clear;
  assign o_pwm_permit = pwm_permit;
  assign o_master_gate = master_gate;
  assign o_down_prog = !master_gate;
  assign o_trip_latch = trip_latch;
  assign o_trip_lamp = trip_latch;
  assign o_volt_reg_lamp = volt_lamp;
  assign o_amp_reg_lamp = amp_lamp;
  assign o_unreg_lamp = unreg_lamp;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_delay_set;
    delay_q && !delay_d && cut_all_n;
  endsequence

  property p_pulse_start;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      s_delay_set |=> pwm_q;
  endproperty
  a_pulse_start: assert property (p_pulse_start) else $error("pulse not started");

  property p_cut_ends;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      !cut_all_n |=> !pwm_q;
  endproperty
  a_cut_ends: assert property (p_cut_ends) else $error("cutoff ignored");

  property p_delay_held;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      i_clk20k |=> !delay_q && !pwm_q;
  endproperty
  a_delay_held: assert property (p_delay_held) else $error("delay flop not held");

  sequence s_pwm_end;
    pwm_d && !pwm_q;
  endsequence

  property p_off_pulse;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      s_pwm_end |=> o_off_pulse [*8] ##0 !o_switch_on;
  endproperty
  a_off_pulse: assert property (p_off_pulse) else $error("no off pulse");

  property p_trip_hold;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      trip_latch && power_clear && !i_remote_reset |=> trip_latch;
  endproperty
  a_trip_hold: assert property (p_trip_hold) else $error("trip latch lost");

  property p_trip_clear;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      !power_clear && !i_out_overvolt |=> !o_trip_lamp;
  endproperty
  a_trip_clear: assert property (p_trip_clear) else $error("trip not cleared");

  property p_gate;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      trip_latch || !sif.permit |-> !o_master_gate && o_down_prog ##1 !pwm_q;
  endproperty
  a_gate: assert property (p_gate) else $error("gate open while inhibited");

  property p_bias;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      !i_bias_ok |=> !o_power_clear && !o_relay_enable && !o_on_pulse;
  endproperty
  a_bias: assert property (p_bias) else $error("drivers not inhibited");

  property p_gap;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      gap_full && !i_mains_present |=> !o_pwm_permit;
  endproperty
  a_gap: assert property (p_gap) else $error("mains gap not tripped");
endmodule // spt_core

//--- core/spt_pkg.sv
package spt_pkg;
  // System clock
  localparam int CLK_HZ = 200_000_000;
  localparam int CLK_KHZ = CLK_HZ / 1000;
  // Sequencer tick: the 20 kHz pacing clock divided by sixteen
  localparam int DIV_W = 4;
  localparam logic [DIV_W-1:0] DIV_LAST = 4'hf;
  localparam int TICK_HZ = 1250;
  localparam int RELAY_MS = 1000;
  localparam int PERMIT_MS = 1100;
  localparam int TICK_W = 11;
  localparam logic [TICK_W-1:0] RELAY_TICKS = TICK_W'(RELAY_MS * TICK_HZ / 1000);
  localparam logic [TICK_W-1:0] PERMIT_TICKS = TICK_W'(PERMIT_MS * TICK_HZ / 1000);
  // Mains interruption that forces a restart (longest time, rounded down)
  localparam int MAINS_GAP_MS = 20;
  localparam int MAINS_GAP_CYC = MAINS_GAP_MS * CLK_KHZ;
  // Switch drive pulse train
  localparam int ON_RATE_HZ = 160_000;
  localparam int ON_PERIOD_CYC = CLK_HZ / ON_RATE_HZ;
  localparam int ON_PULSES_MAX = 4;
  localparam int PULSE_W_NS = 500;
  localparam int PULSE_W_CYC = (PULSE_W_NS * CLK_KHZ + 999_999) / 1_000_000;
  localparam int PHASE_W = 11;
  localparam int NUM_W = 3;
  localparam int WID_W = 7;
  // Turn-on sequencer states
  typedef enum logic [2:0] {
    SEQ_COUNT = 3'h1,
    SEQ_RELAY = 3'h2,
    SEQ_RUN = 3'h4
  } spt_seq_state_t;
endpackage

//--- core/spt_seq.sv
`timescale 1ns/1ps
module spt_seq (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // Link to the core
  spt_seq_if.seq sif
);
  // ****************************************
  // Divider and tick counter
  // ****************************************
  logic [spt_pkg::DIV_W-1:0] div_cnt;
  logic [spt_pkg::TICK_W-1:0] tick_cnt;
  spt_pkg::spt_seq_state_t state;
  spt_pkg::spt_seq_state_t next_state;
  wire hold = sif.seq_clear;
  wire tick = sif.clk20_rise && (div_cnt == spt_pkg::DIV_LAST);
  wire running = (state != spt_pkg::SEQ_RUN);
  wire [spt_pkg::TICK_W-1:0] next_tick = tick_cnt + 1'b1;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || hold) begin
      div_cnt <= '0;
      tick_cnt <= '0;
    end else if (running && sif.clk20_rise) begin
      div_cnt <= div_cnt + 1'b1;
      if (tick) begin
        tick_cnt <= next_tick;
      end
    end
  end

  // ****************************************
  // State
  // ****************************************
  always_comb begin
    next_state = state;
    case (state)
      spt_pkg::SEQ_COUNT: begin
        if (tick && next_tick == spt_pkg::RELAY_TICKS) begin
          next_state = spt_pkg::SEQ_RELAY;
        end
      end
      spt_pkg::SEQ_RELAY: begin
        if (tick && next_tick == spt_pkg::PERMIT_TICKS) begin
          next_state = spt_pkg::SEQ_RUN;
        end
      end
      spt_pkg::SEQ_RUN: begin
        next_state = spt_pkg::SEQ_RUN;
      end
      default: begin
        next_state = spt_pkg::SEQ_COUNT;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || hold) begin
      state <= spt_pkg::SEQ_COUNT;
    end else begin
      state <= next_state;
    end
  end

  assign sif.relay_en = (state != spt_pkg::SEQ_COUNT);
  assign sif.permit = (state == spt_pkg::SEQ_RUN);

  // ****************************************
  // Checks
  // ****************************************
  property p_permit_hold;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      sif.permit && !hold |=> sif.permit && $stable(tick_cnt);
  endproperty
  a_permit_hold: assert property (p_permit_hold) else $error("permit dropped");

  property p_clear_resets;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      hold |=> !sif.relay_en && !sif.permit && tick_cnt == '0;
  endproperty
  a_clear_resets: assert property (p_clear_resets) else $error("hold ignored");

  property p_permit_after_relay;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      $rose(sif.permit) |-> sif.relay_en && tick_cnt == spt_pkg::PERMIT_TICKS;
  endproperty
  a_permit_after_relay: assert property (p_permit_after_relay) else $error("permit early");
endmodule // spt_seq

//--- core/spt_seq_if.sv
`timescale 1ns/1ps
interface spt_seq_if;
  logic seq_clear;
  logic clk20_rise;
  logic relay_en;
  logic permit;
  modport core (output seq_clear, output clk20_rise, input relay_en, input permit);
  modport seq (input seq_clear, input clk20_rise, output relay_en, output permit);
endinterface

//--- verification/spt_analog_model.sv
`timescale 1ns/1ps
// ****
// Analog side: pacing clocks and ramp comparators
// ****
module spt_analog_model (
  // Clock
  input wire logic i_ref_clk,
  // Settings from the bench
  input wire logic [15:0] i_hi_cyc,
  input wire logic [15:0] i_lo_cyc,
  input wire logic [15:0] i_ctrl_lvl,
  input wire logic [15:0] i_lim_lvl,
  // Modulator pulse
  input wire logic i_pwm,
  // Pacing clocks and comparators
  output logic o_clk20k,
  output logic o_osc320k,
  output logic o_over_ctrl,
  output logic o_over_limit
);
  logic [15:0] ph;
  logic [15:0] ramp;
  logic [31:0] per;
  assign per = 32'(i_hi_cyc) + 32'(i_lo_cyc);
  initial begin
    ph = 16'h0;
    ramp = 16'h0;
    o_clk20k = 1'b0;
    o_osc320k = 1'b0;
    o_over_ctrl = 1'b0;
    o_over_limit = 1'b0;
  end
  // Ramp stands for primary current, so it only grows while the switch conducts
  always @(posedge i_ref_clk) begin
    ph <= (32'(ph) + 32'h1 >= per) ? 16'h0 : ph + 16'h1;
    o_clk20k <= ph < i_hi_cyc;
    o_osc320k <= (((32'(ph) * 32'h20) / per) % 32'h2) == 32'h1;
    ramp <= i_pwm ? ramp + 16'h1 : 16'h0;
    o_over_ctrl <= i_pwm && (ramp >= i_ctrl_lvl);
    o_over_limit <= i_pwm && (ramp >= i_lim_lvl);
  end
endmodule // spt_analog_model

//--- verification/test_supply_pwm_turnon_sequencer.sv
`timescale 1ns/1ps
module test_supply_pwm_turnon_sequencer;
  // ****
  // Signals and instances
  // ****
  localparam int MGAP = 50;
  logic i_ref_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_bias_ok = 1'b0;
  logic i_mains_present = 1'b1;
  logic i_mains_surge = 1'b0;
  logic i_out_overvolt = 1'b0;
  logic i_remote_reset = 1'b0;
  logic i_volt_below_port = 1'b0;
  logic i_amp_below_port = 1'b0;
  logic [15:0] hi_cyc = 16'h1;
  logic [15:0] lo_cyc = 16'h1;
  logic [15:0] ctrl_lvl = 16'hffff;
  logic [15:0] lim_lvl = 16'hffff;
  logic [15:0] seed = 16'h75cd;
  logic i_clk20k, i_osc320k, i_ramp_over_ctrl, i_ramp_over_limit;
  logic o_pwm, o_switch_on, o_on_pulse, o_off_pulse, o_control_cutoff_n, o_power_cutoff_n;
  logic o_power_clear, o_relay_enable, o_pwm_permit, o_master_gate, o_down_prog;
  logic o_trip_latch, o_trip_lamp, o_volt_reg_lamp, o_amp_reg_lamp, o_unreg_lamp;
  logic meas = 1'b0;
  logic armed = 1'b0;
  logic p_pwm, p_pc, p_ovc, p_ovl, p_c20, p_on, p_off;
  int mismatches = 0;
  int checks_done = 0;
  int cyc, up, n20, nrise, nper, non, noff, trise, t20, t20f, w, lv, k;

  spt_analog_model far_u (.i_ref_clk(i_ref_clk), .i_hi_cyc(hi_cyc), .i_lo_cyc(lo_cyc),
    .i_ctrl_lvl(ctrl_lvl), .i_lim_lvl(lim_lvl), .i_pwm(o_pwm), .o_clk20k(i_clk20k),
    .o_osc320k(i_osc320k), .o_over_ctrl(i_ramp_over_ctrl), .o_over_limit(i_ramp_over_limit));
  spt_core #(.MAINS_GAP_CYC(MGAP)) dut_u (.i_ref_clk, .i_rstn, .i_clk20k, .i_osc320k,
    .i_ramp_over_ctrl, .i_ramp_over_limit, .i_volt_below_port, .i_amp_below_port, .i_bias_ok,
    .i_mains_present, .i_mains_surge, .i_out_overvolt, .i_remote_reset, .o_pwm, .o_switch_on,
    .o_on_pulse, .o_off_pulse, .o_control_cutoff_n, .o_power_cutoff_n, .o_power_clear,
    .o_relay_enable, .o_pwm_permit, .o_master_gate, .o_down_prog, .o_trip_latch, .o_trip_lamp,
    .o_volt_reg_lamp, .o_amp_reg_lamp, .o_unreg_lamp);

  // ****
  // Helpers
  // ****
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // One on-pulse per on-period of a modulator pulse, capped at four
  function automatic int on_exp(input int wd);
    int n;
    n = 1 + wd / 1250;
    return (wd <= 0) ? 0 : (n > 4 ? 4 : n);
  endfunction
  task automatic check(input logic seen, input logic exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic wait_rise;
    while (i_clk20k) @(posedge i_ref_clk);
    while (!i_clk20k) @(posedge i_ref_clk);
  endtask
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial forever #2.5 i_ref_clk = ~i_ref_clk;
  initial begin
    repeat (99000) @(posedge i_ref_clk);
    mismatches++;
    finish_test();
  end

  // ****
  // Monitor: reads the values settled before each edge
  // ****
  always @(posedge i_ref_clk) begin
    cyc++;
    up = i_rstn ? up + 1 : 0;
    if (up > 3) begin
      check(o_switch_on, p_pwm & p_pc, "switch drive");
      check(o_control_cutoff_n, !p_ovc, "control cutoff");
      check(o_power_cutoff_n, !p_ovl, "power cutoff");
      check(o_master_gate, o_pwm_permit & !o_trip_latch, "master gate");
      check(o_down_prog, !o_master_gate, "down programming");
      check(o_trip_lamp, o_trip_latch, "trip lamp");
    end
    if (!o_power_clear || i_mains_surge || !i_mains_present) n20 = 0;
    else if (i_clk20k && !p_c20) n20++;
    if (i_clk20k && !p_c20) begin
      t20 = cyc;
      nper++;
    end
    if (!i_clk20k && p_c20) t20f = cyc;
    if (o_on_pulse && !p_on) non++;
    if (o_off_pulse && !p_off) noff++;
    if (o_pwm && !p_pwm && up > 3) begin
      nrise++;
      if (meas && armed) begin
        check(nper == 1, 1'b1, "pulses per period");
        check(non >= on_exp(w - 3) && non <= on_exp(w), 1'b1, "on pulses");
        check(noff == 1, 1'b1, "off pulse");
      end
      if (meas) check(cyc - t20f >= 2 && cyc - t20f <= 340, 1'b1, "pulse start");
      armed = meas;
      trise = cyc;
      nper = 0;
      non = 0;
      noff = 0;
    end
    if (!o_pwm && p_pwm && up > 3) begin
      w = cyc - trise;
      lv = (ctrl_lvl < lim_lvl) ? int'(ctrl_lvl) : int'(lim_lvl);
      if (meas) check(w <= lv + 6 && (w >= lv || cyc - t20 <= 4), 1'b1, "pulse end");
    end
    p_pwm = o_pwm;
    p_pc = o_power_clear;
    p_ovc = i_ramp_over_ctrl;
    p_ovl = i_ramp_over_limit;
    p_c20 = i_clk20k;
    p_on = o_on_pulse;
    p_off = o_off_pulse;
  end

  // ****
  // Main sequence
  // ****
  initial begin
    step(10);
    i_rstn <= 1'b1;
    step(2);
    check(o_down_prog, 1'b1, "reset down prog");
    check(o_pwm | o_relay_enable | o_trip_latch, 1'b0, "reset state");
    step(20);
    check(o_power_clear | o_on_pulse, 1'b0, "bias low");
    i_bias_ok <= 1'b1;
    step(2);
    check(o_power_clear, 1'b1, "power clear");
    while (n20 < 1000) step(1);
    i_mains_surge <= 1'b1;
    step(1);
    i_mains_surge <= 1'b0;
    for (k = 0; k < 50000 && o_relay_enable !== 1'b1; k++) step(1);
    check(n20 >= 19998 && n20 <= 20001, 1'b1, "relay time");
    check(o_pwm_permit, 1'b0, "permit early");
    for (k = 0; k < 5000 && o_pwm_permit !== 1'b1; k++) step(1);
    check(n20 >= 21998 && n20 <= 22001, 1'b1, "permit time");
    for (k = 0; k < 4; k++) begin
      i_volt_below_port <= k[0];
      i_amp_below_port <= k[1];
      step(2);
      check(o_volt_reg_lamp, k[0], "volt lamp");
      check(o_amp_reg_lamp, k[1], "amp lamp");
      check(o_unreg_lamp, !(k[0] | k[1]), "unregulated lamp");
    end
    hi_cyc <= 16'h64;
    lo_cyc <= 16'h1450;
    wait_rise();
    // Levels move only after the previous pulse has surely ended
    for (k = 0; k < 5; k++) begin
      wait_rise();
      step(10);
      seed = lfsr(seed);
      ctrl_lvl <= (k == 0) ? 16'hffff : (k == 1) ? 16'h0 : {3'h0, seed[12:0]};
      seed = lfsr(seed);
      lim_lvl <= (k == 0) ? 16'hffff : {3'h0, seed[12:0]};
      meas <= 1'b1;
    end
    wait_rise();
    wait_rise();
    meas <= 1'b0;
    check(o_pwm_permit & o_relay_enable, 1'b1, "permit held");
    i_out_overvolt <= 1'b1;
    step(1);
    i_out_overvolt <= 1'b0;
    step(3);
    check(o_trip_latch & o_down_prog, 1'b1, "trip set");
    lv = nrise;
    step(5400);
    check(nrise == lv && o_trip_latch, 1'b1, "tripped pulses");
    i_remote_reset <= 1'b1;
    step(1);
    i_remote_reset <= 1'b0;
    step(2);
    check(o_trip_latch, 1'b0, "remote reset");
    i_remote_reset <= 1'b1;
    i_out_overvolt <= 1'b1;
    step(1);
    i_remote_reset <= 1'b0;
    i_out_overvolt <= 1'b0;
    step(2);
    check(o_trip_latch, 1'b1, "overvoltage wins");
    i_mains_present <= 1'b0;
    step(MGAP - 10);
    i_mains_present <= 1'b1;
    step(2);
    check(o_pwm_permit, 1'b1, "short gap");
    i_mains_present <= 1'b0;
    step(MGAP + 3);
    check(o_pwm_permit, 1'b0, "long gap");
    i_mains_present <= 1'b1;
    i_bias_ok <= 1'b0;
    step(3);
    check(o_trip_latch | o_power_clear | o_relay_enable, 1'b0, "clear at bias loss");
    finish_test();
  end
endmodule // test_supply_pwm_turnon_sequencer
